// file: hw/dcdf_fifo.v
// Deep 36-bit buffer core with independent write and read ports.
// All pins are sampled by the 100 MHz core clock; port clocks are
// much slower and arrive as ordinary pins.
`timescale 1ns/1ps
`include "dcdf_defines.vh"
module dcdf_fifo #(
    parameter ADDR_W = `DCDF_ADDR_W,
    parameter DATA_W = `DCDF_DATA_W
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire write_clk_i,
    input wire write_strobe_i,
    input wire write_enable_n_i,
    input wire write_chip_select_n_i,
    input wire [DATA_W-1:0] data_in_i,
    input wire read_clk_i,
    input wire read_strobe_i,
    input wire read_enable_n_i,
    input wire read_chip_select_n_i,
    input wire output_enable_n_i,
    input wire master_reset_n_i,
    input wire partial_reset_n_i,
    input wire mode_sel_serial_in_i,
    input wire offset_default_sel0_i,
    input wire offset_default_sel1_i,
    input wire offset_load_n_i,
    input wire serial_clk_i,
    input wire serial_load_enable_n_i,
    input wire flag_mode_sel_i,
    input wire read_port_timing_sel_i,
    input wire write_port_timing_sel_i,
    input wire mark_i,
    input wire retransmit_n_i,
    output reg [DATA_W-1:0] data_out_o,
    output reg data_out_oe_o,
    output reg [1:0] empty_flag_n_o,
    output reg [1:0] full_flag_n_o,
    output reg [1:0] almost_empty_n_o,
    output reg [1:0] almost_full_n_o,
    output reg fall_through_mode_o,
    output reg standby_o
);
    localparam PIN_W = `DCDF_P_CTL_W + DATA_W;
    localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};

    // Default offset lookup
    function [ADDR_W-1:0] ofs_default;
        input [2:0] sel;
        reg [31:0] v;
        begin
            case (sel)
                3'd0: v = `DCDF_OFS_DEF0;
                3'd1: v = `DCDF_OFS_DEF1;
                3'd2: v = `DCDF_OFS_DEF2;
                3'd3: v = `DCDF_OFS_DEF3;
                3'd4: v = `DCDF_OFS_DEF4;
                3'd5: v = `DCDF_OFS_DEF5;
                3'd6: v = `DCDF_OFS_DEF6;
                default: v = `DCDF_OFS_DEF7;
            endcase
            ofs_default = v[ADDR_W-1:0];
        end
    endfunction

    // Widen offset to count width
    function [ADDR_W:0] widen;
        input [ADDR_W-1:0] ofs;
        begin
            widen = {1'b0, ofs};
        end
    endfunction

    wire [PIN_W-1:0] pins; // Filtered pin levels
    reg [4:0] clk_prev; // Previous levels of the five clock-like pins
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Storage array
    reg [ADDR_W:0] wr_ptr; // Write pointer, extra wrap bit
    reg [ADDR_W:0] rd_ptr; // Read pointer, extra wrap bit
    reg [ADDR_W:0] mark_ptr; // Marked read location
    reg [ADDR_W-1:0] ae_ofs; // Almost-empty offset
    reg [ADDR_W-1:0] af_ofs; // Almost-full offset
    reg ofs_wr_sel; // Next parallel write goes to almost-full
    reg ofs_rd_sel; // Next offset read shows almost-full
    reg wr_sync; // Write port clocked
    reg rd_sync; // Read port clocked
    reg flag_sync; // Almost flags in clocked mode
    reg serial_mode; // Offsets loaded serially
    reg out_valid; // Fall-through output register holds a word
    reg [1:0] trans_cnt; // Read-clock transitions while waiting
    reg rd_sel_q; // Read select sampled on read clock
    reg empty_n; // Working copies of status flags
    reg full_n;
    reg ae_n;
    reg af_n;
    reg [1:0] evt_q; // Write and read port events, one cycle late

    // One filter bank keeps data and strobes aligned
    dcdf_sync #(
        .W(PIN_W)
    ) u_pins (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i({data_in_i, retransmit_n_i, mark_i,
                write_port_timing_sel_i, read_port_timing_sel_i,
                flag_mode_sel_i, serial_load_enable_n_i,
                offset_load_n_i, offset_default_sel1_i,
                offset_default_sel0_i, mode_sel_serial_in_i,
                partial_reset_n_i, master_reset_n_i,
                output_enable_n_i, read_chip_select_n_i,
                read_enable_n_i, write_chip_select_n_i,
                write_enable_n_i, serial_clk_i, read_strobe_i,
                read_clk_i, write_strobe_i, write_clk_i}),
        .level_o(pins)
    );

    wire [DATA_W-1:0] din = pins[PIN_W-1:`DCDF_P_CTL_W];
    wire [4:0] rise = pins[4:0] & ~clk_prev; // One-cycle edge pulses
    wire [4:0] fall = ~pins[4:0] & clk_prev;
    wire load_n = pins[`DCDF_P_LOAD];
    wire mrst = ~pins[`DCDF_P_MRST];
    wire prst = ~pins[`DCDF_P_PRST];

    // Port events, each on its own pin
    wire wr_evt = wr_sync ? (rise[`DCDF_P_WCLK] & ~pins[`DCDF_P_WEN])
                          : rise[`DCDF_P_WSTB];
    wire rd_evt = rd_sync ? (rise[`DCDF_P_RCLK] & ~pins[`DCDF_P_REN])
                          : rise[`DCDF_P_RSTB];
    wire rclk_evt = rd_sync ? rise[`DCDF_P_RCLK] : rise[`DCDF_P_RSTB];
    wire wclk_evt = wr_sync ? rise[`DCDF_P_WCLK] : rise[`DCDF_P_WSTB];
    wire rtrans = rd_sync ? (rise[`DCDF_P_RCLK] | fall[`DCDF_P_RCLK])
                          : (rise[`DCDF_P_RSTB] | fall[`DCDF_P_RSTB]);

    wire [ADDR_W:0] count = wr_ptr - rd_ptr; // Words in the array
    wire mem_empty = (count == {(ADDR_W+1){1'b0}});
    wire mem_full = (count == DEPTH);

    // Data writes need load high, select low
    wire do_write = wr_evt & load_n & ~pins[`DCDF_P_WSEL] & ~mem_full;
    wire ofs_write = wr_evt & ~load_n & ~serial_mode;
    wire ofs_shift = rise[`DCDF_P_SCLK] & ~pins[`DCDF_P_SEN] & ~load_n
                     & serial_mode;
    wire ofs_read = rd_evt & ~load_n;
    // Standard read, or fall-through advance
    wire std_read = rd_evt & load_n & ~fall_through_mode_o & ~mem_empty;
    wire ft_pop = rd_evt & load_n & fall_through_mode_o & out_valid;
    wire ft_fill = fall_through_mode_o & ~out_valid & ~mem_empty
                   & rtrans & (trans_cnt == `DCDF_FALL_THROUGH_MODE_TRANS - 2'd1);
    wire take = std_read | (ft_pop & ~mem_empty) | ft_fill;

    wire ae_cond = (count <= widen(ae_ofs)); // At or below threshold
    wire af_cond = (count >= DEPTH - widen(af_ofs));

    // Array write port, storage not reset
    always @(posedge core_clk_i) begin
        if (do_write) begin
            mem[wr_ptr[ADDR_W-1:0]] <= din;
        end
    end

    // Edge history; flags see events once pointers have moved
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            clk_prev <= 5'h00;
            evt_q <= 2'b00;
        end else begin
            clk_prev <= pins[4:0];
            evt_q <= {wclk_evt, rclk_evt};
        end
    end

    // Straps taken while master reset is held
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            fall_through_mode_o <= 1'b0;
            wr_sync <= 1'b1;
            rd_sync <= 1'b1;
            flag_sync <= 1'b1;
            serial_mode <= 1'b0;
            ae_ofs <= ofs_default(3'h0);
            af_ofs <= ofs_default(3'h0);
            ofs_wr_sel <= 1'b0;
        end else if (mrst) begin
            // Async read port forces standard timing
            fall_through_mode_o <= pins[`DCDF_P_SI]
                                   & pins[`DCDF_P_READ_PORT_TIMING_SEL];
            wr_sync <= pins[`DCDF_P_WRITE_PORT_TIMING_SEL];
            rd_sync <= pins[`DCDF_P_READ_PORT_TIMING_SEL];
            flag_sync <= pins[`DCDF_P_PFM];
            serial_mode <= load_n;
            ae_ofs <= ofs_default({load_n, pins[`DCDF_P_FS1],
                                   pins[`DCDF_P_FS0]});
            af_ofs <= ofs_default({load_n, pins[`DCDF_P_FS1],
                                   pins[`DCDF_P_FS0]});
            ofs_wr_sel <= 1'b0;
        end else if (ofs_shift) begin
            // Serial bits enter at the almost-full end
            {ae_ofs, af_ofs} <= {ae_ofs[ADDR_W-2:0], af_ofs,
                                 pins[`DCDF_P_SI]};
        end else if (ofs_write) begin
            // Parallel writes alternate: almost-empty, then almost-full
            if (ofs_wr_sel) begin
                af_ofs <= din[ADDR_W-1:0];
            end else begin
                ae_ofs <= din[ADDR_W-1:0];
            end
            ofs_wr_sel <= ~ofs_wr_sel;
        end else if (prst) begin
            // Partial reset keeps offsets and modes
            ofs_wr_sel <= 1'b0;
        end
    end

    // Pointers, mark and retransmit
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {(ADDR_W+1){1'b0}};
            rd_ptr <= {(ADDR_W+1){1'b0}};
            mark_ptr <= {(ADDR_W+1){1'b0}};
        end else if (mrst | prst) begin
            wr_ptr <= {(ADDR_W+1){1'b0}};
            rd_ptr <= {(ADDR_W+1){1'b0}};
            mark_ptr <= {(ADDR_W+1){1'b0}};
        end else begin
            if (do_write) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            // Retransmit wins over a read
            if (rclk_evt & ~pins[`DCDF_P_RT]) begin
                rd_ptr <= mark_ptr;
            end else if (take) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (rclk_evt & pins[`DCDF_P_MARK]) begin
                mark_ptr <= rd_ptr;
            end
        end
    end

    // Output register, fall-through fill and offset readback
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            data_out_o <= {DATA_W{1'b0}};
            out_valid <= 1'b0;
            trans_cnt <= 2'd0;
            ofs_rd_sel <= 1'b0;
        end else if (mrst | prst) begin
            data_out_o <= {DATA_W{1'b0}};
            out_valid <= 1'b0;
            trans_cnt <= 2'd0;
            ofs_rd_sel <= 1'b0;
        end else begin
            if (ofs_read) begin
                // Offsets alternate, low bits of the bus
                data_out_o <= ofs_rd_sel ? {{(DATA_W-ADDR_W){1'b0}}, af_ofs}
                              : {{(DATA_W-ADDR_W){1'b0}}, ae_ofs};
                ofs_rd_sel <= ~ofs_rd_sel;
            end else if (take) begin
                data_out_o <= mem[rd_ptr[ADDR_W-1:0]];
            end
            // Fall-through word shows after three transitions
            if (ft_fill) begin
                out_valid <= 1'b1;
                trans_cnt <= 2'd0;
            end else if (ft_pop) begin
                out_valid <= ~mem_empty;
            end else if (fall_through_mode_o & ~out_valid & ~mem_empty
                         & rtrans) begin
                trans_cnt <= trans_cnt + 2'd1;
            end else if (mem_empty) begin
                trans_cnt <= 2'd0;
            end
        end
    end

    // Read select sampled on read clock
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rd_sel_q <= 1'b1;
            data_out_oe_o <= 1'b0;
        end else begin
            if (rclk_evt) begin
                rd_sel_q <= pins[`DCDF_P_RSEL];
            end
            data_out_oe_o <= ~pins[`DCDF_P_OEN] & ~rd_sel_q;
        end
    end

    // Status flags
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            empty_n <= `DCDF_EMPTY_RST;
            full_n <= `DCDF_FULL_RST;
            ae_n <= `DCDF_AEMPTY_RST;
            af_n <= `DCDF_AFULL_RST;
        end else if (mrst | prst) begin
            // Partial reset keeps modes and offsets
            empty_n <= `DCDF_EMPTY_RST;
            full_n <= `DCDF_FULL_RST;
            ae_n <= `DCDF_AEMPTY_RST;
            af_n <= `DCDF_AFULL_RST;
        end else begin
            // Empty in standard mode, output ready in fall-through
            empty_n <= fall_through_mode_o ? out_valid
                       : ~mem_empty;
            full_n <= ~mem_full;
            if (flag_sync) begin
                if (evt_q[0]) begin
                    ae_n <= ~ae_cond;
                end
                if (evt_q[1]) begin
                    af_n <= ~af_cond;
                end
            end else begin
                // Assert on one port's edge, release on the other's
                if (evt_q[0] & ae_cond) begin
                    ae_n <= 1'b0;
                end else if (evt_q[1] & ~ae_cond) begin
                    ae_n <= 1'b1;
                end
                if (evt_q[1] & af_cond) begin
                    af_n <= 1'b0;
                end else if (evt_q[0] & ~af_cond) begin
                    af_n <= 1'b1;
                end
            end
        end
    end

    // Pin copies; outside logic combines each pair
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            empty_flag_n_o <= {2{`DCDF_EMPTY_RST}};
            full_flag_n_o <= {2{`DCDF_FULL_RST}};
            almost_empty_n_o <= {2{`DCDF_AEMPTY_RST}};
            almost_full_n_o <= {2{`DCDF_AFULL_RST}};
        end else begin
            empty_flag_n_o <= {2{empty_n}};
            full_flag_n_o <= {2{full_n}};
            almost_empty_n_o <= {2{ae_n}};
            almost_full_n_o <= {2{af_n}};
        end
    end

    // Standby when no write or read event, offset shift, fall-through fill or reset this cycle
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            standby_o <= 1'b0;
        end else begin
            standby_o <= ~(wr_evt | rd_evt | ofs_shift | ft_fill
                           | mrst | prst);
        end
    end
endmodule

// file: hw/dcdf_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes every bit comes from outside the core clock domain.
`timescale 1ns/1ps
module dcdf_sync #(
    parameter W = 1
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire [W-1:0] pin_i,
    output reg [W-1:0] level_o
);
    reg [W-1:0] stage1; // Metastable stage, read by stage2 only
    reg [W-1:0] stage2; // Settled copy
    reg [W-1:0] stage3; // Delayed copy for agreement

    // A change is taken only once stage2 and stage3 agree
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
            stage3 <= {W{1'b0}};
            level_o <= {W{1'b0}};
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            // Set where both high, clear where both low, else hold
            level_o <= (stage2 & stage3) | (level_o & (stage2 | stage3));
        end
    end
endmodule

// file: shared/dcdf_defines.vh
// Constants for the deep dual-port buffer core: widths, reset values,
// default almost-flag offsets and the fall-through delay.
// Included by bare name; holds definitions only.
`ifndef DCDF_DEFINES_VH
`define DCDF_DEFINES_VH

// Word width and default address width (depth is two to this power)
`define DCDF_DATA_W 36
`define DCDF_ADDR_W 19

// Read-clock transitions before a fall-through word shows
`define DCDF_FALL_THROUGH_MODE_TRANS 2'd3

// Flag levels after reset (all active low)
`define DCDF_EMPTY_RST 1'b0
`define DCDF_FULL_RST 1'b1
`define DCDF_AEMPTY_RST 1'b0
`define DCDF_AFULL_RST 1'b1

// Eight default offsets, picked by {load, sel1, sel0} at master reset
`define DCDF_OFS_DEF0 32'd7
`define DCDF_OFS_DEF1 32'd15
`define DCDF_OFS_DEF2 32'd31
`define DCDF_OFS_DEF3 32'd63
`define DCDF_OFS_DEF4 32'd127
`define DCDF_OFS_DEF5 32'd255
`define DCDF_OFS_DEF6 32'd511
`define DCDF_OFS_DEF7 32'd1023

// Positions of the control pins inside the sampled pin vector
`define DCDF_P_WCLK 0
`define DCDF_P_WSTB 1
`define DCDF_P_RCLK 2
`define DCDF_P_RSTB 3
`define DCDF_P_SCLK 4
`define DCDF_P_WEN 5
`define DCDF_P_WSEL 6
`define DCDF_P_REN 7
`define DCDF_P_RSEL 8
`define DCDF_P_OEN 9
`define DCDF_P_MRST 10
`define DCDF_P_PRST 11
`define DCDF_P_SI 12
`define DCDF_P_FS0 13
`define DCDF_P_FS1 14
`define DCDF_P_LOAD 15
`define DCDF_P_SEN 16
`define DCDF_P_PFM 17
`define DCDF_P_READ_PORT_TIMING_SEL 18
`define DCDF_P_WRITE_PORT_TIMING_SEL 19
`define DCDF_P_MARK 20
`define DCDF_P_RT 21
`define DCDF_P_CTL_W 22

`endif

// file: sim/dcdf_fifo_sva.sv
// Checker for the buffer core pins.
// Assumes pins sampled by the core clock.
`timescale 1ns/1ps
module dcdf_fifo_sva #(
    parameter DATA_W = 36
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire read_clk_i,
    input wire read_strobe_i,
    input wire read_enable_n_i,
    input wire write_clk_i,
    input wire write_strobe_i,
    input wire serial_clk_i,
    input wire output_enable_n_i,
    input wire master_reset_n_i,
    input wire partial_reset_n_i,
    input wire [DATA_W-1:0] data_out_o,
    input wire data_out_oe_o,
    input wire [1:0] empty_flag_n_o,
    input wire [1:0] full_flag_n_o,
    input wire [1:0] almost_empty_n_o,
    input wire [1:0] almost_full_n_o,
    input wire fall_through_mode_o,
    input wire standby_o
);
    reg [4:0] last; // Port clock levels one cycle ago
    reg [4:0] rd_quiet; // Quiet read-side cycles
    reg [4:0] all_quiet; // Quiet cycles
    wire [4:0] now = {serial_clk_i, write_strobe_i, write_clk_i,
        read_strobe_i, read_clk_i};
    wire resets = !master_reset_n_i || !partial_reset_n_i;
    wire rd_act = resets || (now[1:0] != last[1:0]);
    wire any_act = resets || (now != last);

    // Saturating: never wraps to look busy
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            last <= 5'h00;
            rd_quiet <= 5'h00;
            all_quiet <= 5'h00;
        end else begin
            last <= now;
            rd_quiet <= rd_act ? 5'h00 :
                rd_quiet + {4'h0, rd_quiet != 5'h1f};
            all_quiet <= any_act ? 5'h00 :
                all_quiet + {4'h0, all_quiet != 5'h1f};
        end
    end

    default clocking cc @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Pins held past the input filter
    sequence oe_off_s;
        output_enable_n_i [*8];
    endsequence
    sequence mrst_held_s;
        !master_reset_n_i [*8];
    endsequence
    sequence prst_held_s;
        !partial_reset_n_i [*8];
    endsequence
    sequence mrst_idle_s;
        master_reset_n_i [*8];
    endsequence
    // Enabled read of a non-empty standard buffer
    sequence real_read_s;
        $rose(read_clk_i) && !read_enable_n_i &&
            empty_flag_n_o == 2'b11 && !fall_through_mode_o;
    endsequence

    copies_equal_a:
        assert property (!(^empty_flag_n_o) && !(^full_flag_n_o) &&
            !(^almost_empty_n_o) && !(^almost_full_n_o))
        else $error("flag copies disagree");
    empty_full_excl_a:
        assert property (!fall_through_mode_o |->
            !(empty_flag_n_o == 2'b00 && full_flag_n_o == 2'b00))
        else $error("empty and full together");
    oe_gate_a:
        assert property (oe_off_s |-> !data_out_oe_o)
        else $error("driven with enable off");
    master_clear_a:
        assert property (mrst_held_s |-> ##2 (empty_flag_n_o == 2'b00 &&
            full_flag_n_o == 2'b11 && data_out_o == {DATA_W{1'b0}}))
        else $error("master reset incomplete");
    partial_clear_a:
        assert property (prst_held_s |-> ##2 (empty_flag_n_o == 2'b00 &&
            full_flag_n_o == 2'b11))
        else $error("partial reset incomplete");
    mode_hold_a:
        assert property (mrst_idle_s |-> $stable(fall_through_mode_o))
        else $error("mode moved outside reset");
    data_hold_a:
        assert property (rd_quiet >= 5'd12 |-> $stable(data_out_o))
        else $error("word moved without read");
    idle_standby_a:
        assert property (all_quiet >= 5'd12 |-> standby_o)
        else $error("no standby while idle");
    read_wake_a:
        assert property (real_read_s |-> ##[2:8] !standby_o)
        else $error("read kept standby");
endmodule

bind dcdf_fifo dcdf_fifo_sva #(.DATA_W(DATA_W)) i_dcdf_fifo_sva (
    .core_clk_i, .reset_n_i, .read_clk_i, .read_strobe_i,
    .read_enable_n_i, .write_clk_i, .write_strobe_i, .serial_clk_i,
    .output_enable_n_i, .master_reset_n_i, .partial_reset_n_i,
    .data_out_o, .data_out_oe_o, .empty_flag_n_o, .full_flag_n_o,
    .almost_empty_n_o, .almost_full_n_o, .fall_through_mode_o, .standby_o
);

// file: sim/dcdf_port_model.sv
// Writer and reader model for the buffer core.
// Assumes a bench that calls its tasks; port clocks idle low.
`timescale 1ns/1ps
`include "dcdf_defines.vh"
module dcdf_port_model (
    output reg write_clk_o,
    output reg write_strobe_o,
    output reg write_enable_n_o,
    output reg [`DCDF_DATA_W-1:0] data_o,
    output reg read_clk_o,
    output reg read_enable_n_o
);
    // Idle: clocks still, enables off
    initial begin
        write_clk_o = 1'b0;
        write_strobe_o = 1'b0;
        write_enable_n_o = 1'b1;
        data_o = {`DCDF_DATA_W{1'b0}};
        read_clk_o = 1'b0;
        read_enable_n_o = 1'b1;
    end

    // One 125 ns write cycle, word held around the edge
    task put_word(input [`DCDF_DATA_W-1:0] d, input en_n, input stb);
        begin
            data_o = d;
            write_enable_n_o = en_n;
            #62.5;
            if (stb) begin
                write_strobe_o = 1'b1;
            end else begin
                write_clk_o = 1'b1;
            end
            #62.5;
            write_strobe_o = 1'b0;
            write_clk_o = 1'b0;
            write_enable_n_o = !stb;
            data_o = ~d; // Released bus shows no stale word
        end
    endtask

    // One 125 ns read cycle
    task take_word(input en_n);
        begin
            read_enable_n_o = en_n;
            #62.5;
            read_clk_o = 1'b1;
            #62.5;
            read_clk_o = 1'b0;
            read_enable_n_o = 1'b1;
        end
    endtask
endmodule

// file: sim/test_dcdf_fifo.sv
// Bench for the buffer core at depth 16.
// Assumes the port model makes the port clocks.
`timescale 1ns/1ps
`include "dcdf_defines.vh"
module test_dcdf_fifo;
    localparam AW = 4; // Short fill tests
    localparam DEPTH = 1 << AW;
    localparam OFS = 7; // Select 000 default
    reg core_clk_i, reset_n_i;
    reg wcs_n, rcs_n, oe_n, mrst_n, prst_n, mode_sel, load_n;
    reg wr_sel, rd_sel, fmode, mark, rt_n;
    integer n_fail, num_checks, i;
    wire wclk, wstb, wen_n, rclk, ren_n, oe, ftm;
    wire [`DCDF_DATA_W-1:0] din, dout;
    wire [1:0] ef_n, ff_n, ae_n, af_n;

    dcdf_port_model i_dcdf_port_model (
        .write_clk_o(wclk), .write_strobe_o(wstb),
        .write_enable_n_o(wen_n), .data_o(din),
        .read_clk_o(rclk), .read_enable_n_o(ren_n)
    );
    dcdf_fifo #(.ADDR_W(AW)) i_dcdf_fifo (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .write_clk_i(wclk), .write_strobe_i(wstb),
        .write_enable_n_i(wen_n), .write_chip_select_n_i(wcs_n),
        .data_in_i(din), .read_clk_i(rclk), .read_strobe_i(1'b0),
        .read_enable_n_i(ren_n), .read_chip_select_n_i(rcs_n),
        .output_enable_n_i(oe_n), .master_reset_n_i(mrst_n),
        .partial_reset_n_i(prst_n), .mode_sel_serial_in_i(mode_sel),
        .offset_default_sel0_i(1'b0), .offset_default_sel1_i(1'b0),
        .offset_load_n_i(load_n), .serial_clk_i(1'b0),
        .serial_load_enable_n_i(1'b1), .flag_mode_sel_i(fmode),
        .read_port_timing_sel_i(rd_sel), .write_port_timing_sel_i(wr_sel),
        .mark_i(mark), .retransmit_n_i(rt_n), .data_out_o(dout),
        .data_out_oe_o(oe), .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
        .almost_empty_n_o(ae_n), .almost_full_n_o(af_n),
        .fall_through_mode_o(ftm), .standby_o()
    );

    // Core clock, 10 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task step(input integer n);
        begin
            repeat (n) @(posedge core_clk_i);
            #1;
        end
    endtask
    // Port cycle, then filter and flag delay
    task wr(input [`DCDF_DATA_W-1:0] d);
        begin
            i_dcdf_port_model.put_word(d, 1'b0, 1'b0);
            step(10);
        end
    endtask
    task rd(input en_n);
        begin
            i_dcdf_port_model.take_word(en_n);
            step(10);
        end
    endtask
    function [`DCDF_DATA_W-1:0] word(input integer k);
        word = 36'h9c3c30000 + k;
    endfunction
    // Expected standard-mode flags
    function [7:0] flags(input integer n);
        flags = {{2{n != 0}}, {2{n != DEPTH}}, {2{n > OFS}},
            {2{n < DEPTH - OFS}}};
    endfunction
    task chk_word(input [`DCDF_DATA_W-1:0] exp);
        begin
            num_checks = num_checks + 1;
            if (dout !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: word %h not %h", $time, dout, exp);
            end
        end
    endtask
    task chk_flags(input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if ({ef_n, ff_n, ae_n, af_n} !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: flags %b not %b", $time,
                    {ef_n, ff_n, ae_n, af_n}, exp);
            end
        end
    endtask
    task chk_bit(input got, input exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: bit %b not %b", $time, got, exp);
            end
        end
    endtask
    // Straps held through master reset
    task mrst(input fall_through_mode, input wsel, input fm);
        begin
            mode_sel = fall_through_mode;
            wr_sel = wsel;
            fmode = fm;
            load_n = 1'b0; // Parallel, default offsets
            mrst_n = 1'b0;
            step(10);
            mrst_n = 1'b1;
            step(6);
            load_n = 1'b1;
            mode_sel = 1'b0;
            step(6);
        end
    endtask

    // Fill to refusal, drain
    task t_fill;
        begin
            mrst(1'b0, 1'b1, 1'b0);
            for (i = 0; i < DEPTH; i = i + 1) begin
                wr(word(i));
                chk_flags(flags(i + 1));
            end
            wr(word(99));
            chk_flags(flags(DEPTH));
            chk_word(0);
            oe_n = 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                rd(1'b0);
                chk_word(word(i));
                chk_flags(flags(DEPTH - 1 - i));
            end
            chk_bit(oe, 1'b1);
            rd(1'b0); // Empty buffer refuses the read
            chk_word(word(DEPTH - 1));
            load_n = 1'b0;
            rd(1'b0);
            chk_word(OFS);
            load_n = 1'b1;
            oe_n = 1'b1;
            step(10);
            chk_bit(oe, 1'b0);
        end
    endtask
    // Blocked write, mark, retransmit
    task t_mark;
        begin
            wcs_n = 1'b1;
            wr(word(5));
            chk_flags(flags(0));
            wcs_n = 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                wr(word(20 + i));
            end
            mark = 1'b1;
            rd(1'b0);
            mark = 1'b0;
            rd(1'b0);
            chk_word(word(21));
            rt_n = 1'b0;
            rd(1'b1);
            rt_n = 1'b1;
            rd(1'b0);
            chk_word(word(20));
            prst_n = 1'b0;
            step(10);
            prst_n = 1'b1;
            step(10);
            chk_flags(flags(0));
        end
    endtask
    // Strobe-timed write port
    task t_async;
        begin
            mrst(1'b0, 1'b0, 1'b0);
            wr(word(30));
            chk_flags(flags(0));
            i_dcdf_port_model.put_word(word(31), 1'b0, 1'b1);
            step(10);
            chk_flags(flags(1));
            rd(1'b0);
            chk_word(word(31));
        end
    endtask
    // Fall-through, clocked flags
    task t_fall_through_mode;
        begin
            mrst(1'b1, 1'b1, 1'b1);
            chk_bit(ftm, 1'b1);
            wr(word(40));
            chk_flags(8'h33);
            rd(1'b1);
            rd(1'b1);
            chk_word(word(40));
            chk_flags(8'hf3);
            wr(word(41));
            rd(1'b1);
            chk_word(word(40));
            rd(1'b0);
            chk_word(word(41));
            prst_n = 1'b0;
            step(10);
            prst_n = 1'b1;
            step(10);
            chk_bit(ftm, 1'b1);
            chk_flags(8'h33);
        end
    endtask

    task wrap_up;
        begin
            if (n_fail == 0 && num_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    // Watchdog
    initial begin
        #200000;
        n_fail = n_fail + 1;
        wrap_up;
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        reset_n_i = 1'b0;
        {wcs_n, rcs_n, oe_n, mrst_n, prst_n} = 5'h07;
        {mode_sel, load_n, wr_sel, rd_sel} = 4'h7;
        {fmode, mark, rt_n} = 3'h1;
        step(6);
        reset_n_i = 1'b1;
        step(6);
        chk_flags(flags(0));
        chk_bit(ftm, 1'b0);
        t_fill;
        t_mark;
        t_async;
        t_fall_through_mode;
        wrap_up;
    end
endmodule
